//--- design/fepw_ctrl.sv
// Module: flash erase and deferred-write control behind processor SFRs
//
// How it works
// - key 0x55 starts page erase
// - key 0xAA mass-erases if armed, debug enabled
// - other keys ignored; trigger resets zero
// - six-bit page index, resets to zero
// - deferred mode with engine enabled queues write until busy falls
// - otherwise flash writes go out at once if array idle, dropped if busy
// - waiting flag set; extra writes ignored
// - write-enable redirects move-out, self-clears, irq-blocked
// - unlock field must equal 2
`timescale 1ns/1ps
`default_nettype none
module fepw_ctrl
   import fepw_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   input wire logic movx_wr,
   input wire logic [15:0] movx_addr,
   input wire logic [7:0] movx_data,
   input wire logic irq_global_en,
   input wire logic [3:0] modify_unlock_key,
   input wire logic debug_port_link,
   input wire logic ce_enable,
   input wire logic ce_busy,
   input wire logic flash_done,
   output logic flash_wr,
   output logic [15:0] flash_addr,
   output logic [7:0] flash_data,
   output logic page_erase,
   output logic mass_erase,
   output logic [5:0] erase_page,
   output logic [1:0] program_bank_select,
   output logic xram_wr,
   output logic [15:0] xram_addr,
   output logic [7:0] xram_data
);
   // ***********************************************
   // Register state
   // ***********************************************
   logic [7:0] erase_trigger_q; // Last key written
   logic [5:0] page_q; // page_wipe_index
   logic page_fresh_q; // Page index written since last erase
   logic arm_q; // bulk_wipe_arm
   logic defer_q; // deferred_write_enable
   logic pwe_q; // program_store_write_enable
   logic [1:0] bank_q; // program_bank_select
   logic busy_q; // Flash array operation in flight

   // Output flops
   logic flash_wr_q, page_erase_q, mass_erase_q, xram_wr_q;
   logic [15:0] fl_addr_q, xr_addr_q;
   logic [7:0] fl_data_q, xr_data_q;

   // ***********************************************
   // Decode
   // ***********************************************
   wire wr_erase = sfr_wr && (sfr_addr == FEPW_ADDR_ERASE);
   wire wr_ctrl = sfr_wr && (sfr_addr == FEPW_ADDR_CTRL);
   wire wr_bank = sfr_wr && (sfr_addr == FEPW_ADDR_BANK);
   wire wr_page = sfr_wr && (sfr_addr == FEPW_ADDR_PAGE);
   wire unlocked = (modify_unlock_key == FEPW_UNLOCK_VAL);

   // Erase keys; busy array refuses new erases
   wire go_page = wr_erase && unlocked && !busy_q && page_fresh_q
      && (sfr_wdata == FEPW_KEY_PAGE);
   wire go_mass = wr_erase && unlocked && !busy_q && arm_q
      && debug_port_link && (sfr_wdata == FEPW_KEY_MASS);
   wire go_erase = go_page | go_mass;

   // Move-out routing and write modes
   wire to_flash = movx_wr && pwe_q;
   wire to_xram = movx_wr && !pwe_q;
   wire posting = defer_q && ce_enable;
   wire waiting;
   wire ce_fall;
   wire [15:0] q_addr;
   wire [7:0] q_data;
   // Accepted flash write: gated by unlock and waiting flag
   wire fw_ok = to_flash && unlocked && !waiting;
   wire push = fw_ok && posting;
   wire direct = fw_ok && !posting && !busy_q;
   wire drain = waiting && ce_fall && !busy_q;

   // ***********************************************
   // Submodules
   // ***********************************************
   fepw_edge u_edge (
      .clk(clk),
      .reset_n(reset_n),
      .level_in(ce_busy),
      .fall(ce_fall)
   );

   fepw_post_queue u_queue (
      .clk(clk),
      .reset_n(reset_n),
      .push(push),
      .push_addr(movx_addr),
      .push_data(movx_data),
      .pop(drain),
      .full(waiting),
      .held_addr(q_addr),
      .held_data(q_data)
   );

   // ***********************************************
   // Erase trigger and page index
   // ***********************************************
   // Trigger holds last written key; only keys act
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         erase_trigger_q <= FEPW_ERASE_RST;
      end else if (wr_erase) begin
         erase_trigger_q <= sfr_wdata;
      end
   end

   // Page index; the fresh mark is what forces a rewrite per erase
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         page_q <= FEPW_PAGE_RST;
         page_fresh_q <= 1'b0;
      end else if (wr_page) begin
         page_q <= sfr_wdata[FEPW_PAGE_LSB +: 6];
         page_fresh_q <= 1'b1;
      end else if (go_erase) begin
         page_fresh_q <= 1'b0;
      end
   end

   // ***********************************************
   // Control register bits and bank select
   // ***********************************************
   // Arm bit: write sets, any erase start consumes it
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         arm_q <= 1'b0;
      end else if (wr_ctrl) begin
         arm_q <= sfr_wdata[FEPW_BIT_ARM];
      end else if (go_erase) begin
         arm_q <= 1'b0;
      end
   end

   // Deferred enable, plain read/write
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         defer_q <= 1'b0;
      end else if (wr_ctrl) begin
         defer_q <= sfr_wdata[FEPW_BIT_DEFER];
      end
   end

   // Write enable: blocked while irqs on, cleared after each flash byte
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pwe_q <= 1'b0;
      end else if (wr_ctrl && !irq_global_en) begin
         pwe_q <= sfr_wdata[FEPW_BIT_PWE];
      end else if (to_flash) begin
         pwe_q <= 1'b0;
      end
   end

   // Bank select
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         bank_q <= FEPW_BANK_RST;
      end else if (wr_bank) begin
         bank_q <= sfr_wdata[1:0];
      end
   end

   // ***********************************************
   // Array operation tracking and outputs
   // ***********************************************
   // Busy from any start until the array reports done
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         busy_q <= 1'b0;
      end else if (go_erase || direct || drain) begin
         busy_q <= 1'b1;
      end else if (flash_done) begin
         busy_q <= 1'b0;
      end
   end

   // One-cycle start pulses toward the flash array
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         flash_wr_q <= 1'b0;
         page_erase_q <= 1'b0;
         mass_erase_q <= 1'b0;
      end else begin
         flash_wr_q <= direct | drain;
         page_erase_q <= go_page;
         mass_erase_q <= go_mass;
      end
   end

   // Flash write payload: queued entry wins when draining
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         fl_addr_q <= 16'h0000;
         fl_data_q <= 8'h00;
      end else if (drain) begin
         fl_addr_q <= q_addr;
         fl_data_q <= q_data;
      end else if (direct) begin
         fl_addr_q <= movx_addr;
         fl_data_q <= movx_data;
      end
   end

   // Ordinary external RAM path
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         xram_wr_q <= 1'b0;
         xr_addr_q <= 16'h0000;
         xr_data_q <= 8'h00;
      end else begin
         xram_wr_q <= to_xram;
         if (to_xram) begin
            xr_addr_q <= movx_addr;
            xr_data_q <= movx_data;
         end
      end
   end

   // ***********************************************
   // Read path: only control byte and bank are readable
   // ***********************************************
   wire [7:0] ctrl_rd = {4'h0, waiting, defer_q, 1'b0, pwe_q};
   assign sfr_rdata = (sfr_addr == FEPW_ADDR_CTRL) ? ctrl_rd :
      (sfr_addr == FEPW_ADDR_BANK) ? {6'h00, bank_q} : 8'h00;

   assign flash_wr = flash_wr_q;
   assign flash_addr = fl_addr_q;
   assign flash_data = fl_data_q;
   assign page_erase = page_erase_q;
   assign mass_erase = mass_erase_q;
   assign erase_page = page_q;
   assign program_bank_select = bank_q;
   assign xram_wr = xram_wr_q;
   assign xram_addr = xr_addr_q;
   assign xram_data = xr_data_q;
endmodule
`default_nettype wire

//--- design/fepw_edge.sv
// Module: falling-edge detector for the compute engine busy level
`timescale 1ns/1ps
`default_nettype none
module fepw_edge
   import fepw_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic level_in,
   output logic fall
);
   logic prev_q; // Last sampled level

   // Remember previous level; input is already synchronous
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         prev_q <= 1'b0;
      end else begin
         prev_q <= level_in;
      end
   end

   assign fall = prev_q & ~level_in;
endmodule
`default_nettype wire

//--- design/fepw_pkg.sv
// Package: register map, keys and reset values of the flash erase/write control
package fepw_pkg;
   // ***********************************************
   // Register addresses (special function space)
   // ***********************************************
   localparam logic [7:0] FEPW_ADDR_ERASE = 8'h94;  // erase_trigger
   localparam logic [7:0] FEPW_ADDR_CTRL = 8'hb2;   // arm/deferred/waiting/pwe
   localparam logic [7:0] FEPW_ADDR_BANK = 8'hb6;   // program_bank_select
   localparam logic [7:0] FEPW_ADDR_PAGE = 8'hb7;   // page_wipe_index

   // ***********************************************
   // Field positions
   // ***********************************************
   localparam int FEPW_BIT_PWE = 0;    // program_store_write_enable
   localparam int FEPW_BIT_ARM = 1;    // bulk_wipe_arm
   localparam int FEPW_BIT_DEFER = 2;  // deferred_write_enable
   localparam int FEPW_BIT_WAIT = 3;   // deferred_write_waiting
   localparam int FEPW_PAGE_LSB = 2;   // page index sits in [7:2]

   // ***********************************************
   // Keys and reset values
   // ***********************************************
   localparam logic [7:0] FEPW_KEY_PAGE = 8'h55;
   localparam logic [7:0] FEPW_KEY_MASS = 8'haa;
   localparam logic [3:0] FEPW_UNLOCK_VAL = 4'h2;
   localparam logic [7:0] FEPW_ERASE_RST = 8'h00;
   localparam logic [1:0] FEPW_BANK_RST = 2'h1;
   localparam logic [5:0] FEPW_PAGE_RST = 6'h00;
endpackage

//--- design/fepw_post_queue.sv
// Module: one-entry holding slot for deferred flash byte writes
`timescale 1ns/1ps
`default_nettype none
module fepw_post_queue
   import fepw_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic push,
   input wire logic [15:0] push_addr,
   input wire logic [7:0] push_data,
   input wire logic pop,
   output logic full,
   output logic [15:0] held_addr,
   output logic [7:0] held_data
);
   logic full_q; // Slot occupied
   logic [15:0] addr_q; // Held flash address
   logic [7:0] data_q; // Held byte

   // Push only when empty; caller drops pushes while full
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         full_q <= 1'b0;
      end else if (push && !full_q) begin
         full_q <= 1'b1;
      end else if (pop) begin
         full_q <= 1'b0;
      end
   end

   // Payload latches with the push
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         addr_q <= 16'h0000;
         data_q <= 8'h00;
      end else if (push && !full_q) begin
         addr_q <= push_addr;
         data_q <= push_data;
      end
   end

   assign full = full_q;
   assign held_addr = addr_q;
   assign held_data = data_q;
endmodule
`default_nettype wire

//--- test/fepw_ctrl_properties.sv
// Checker: port-level properties of the flash erase and write control
`timescale 1ns/1ps
`default_nettype none
module fepw_ctrl_chk
   import fepw_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata,
   input wire logic movx_wr,
   input wire logic [15:0] movx_addr,
   input wire logic [3:0] modify_unlock_key,
   input wire logic debug_port_link,
   input wire logic ce_enable,
   input wire logic ce_busy,
   input wire logic flash_wr,
   input wire logic page_erase,
   input wire logic mass_erase,
   input wire logic [5:0] erase_page,
   input wire logic xram_wr,
   input wire logic [15:0] xram_addr
);
   // ***********************************************
   // Helper decode and page records
   // ***********************************************
   wire pg_wr = sfr_wr && sfr_addr == FEPW_ADDR_PAGE; // Page index write
   wire er_wr = sfr_wr && sfr_addr == FEPW_ADDR_ERASE; // Trigger write
   wire ctl = sfr_addr == FEPW_ADDR_CTRL; // Control bits on read data
   wire ok = modify_unlock_key == FEPW_UNLOCK_VAL; // Unlocked
   wire mvp = ctl && sfr_rdata[FEPW_BIT_PWE] && movx_wr && !sfr_wr;
   logic [5:0] page_q; // Last page index written
   logic fresh_q; // Page written since last page erase
   // Records stand for what software wrote; fresh mark also clears on page_erase
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         page_q <= 6'h00;
         fresh_q <= 1'h0;
      end else begin
         if (pg_wr) page_q <= sfr_wdata[7:2];
         fresh_q <= pg_wr | (fresh_q & ~page_erase);
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // ***********************************************
   // Properties
   // ***********************************************
   property p_page;
      page_erase |-> $past(er_wr && sfr_wdata == FEPW_KEY_PAGE && ok);
   endproperty
   a_page: assert property (p_page) else $error("stray page erase");
   property p_mass;
      mass_erase |->
         $past(er_wr && sfr_wdata == FEPW_KEY_MASS && debug_port_link && ok);
   endproperty
   a_mass: assert property (p_mass) else $error("stray mass erase");
   property p_junk;
      er_wr && sfr_wdata != FEPW_KEY_PAGE && sfr_wdata != FEPW_KEY_MASS
         |=> !page_erase && !mass_erase;
   endproperty
   a_junk: assert property (p_junk) else $error("junk key acted");
   property p_index;
      page_erase |-> erase_page == page_q;
   endproperty
   a_index: assert property (p_index) else $error("wrong page");
   property p_fresh;
      page_erase |-> fresh_q;
   endproperty
   a_fresh: assert property (p_fresh) else $error("stale page");
   property p_redir;
      ctl && !sfr_rdata[FEPW_BIT_PWE] && movx_wr && !sfr_wr
         |=> xram_wr && xram_addr == $past(movx_addr);
   endproperty
   a_redir: assert property (p_redir) else $error("no ram write");
   property p_clear;
      mvp |=> !(ctl && sfr_rdata[FEPW_BIT_PWE]);
   endproperty
   a_clear: assert property (p_clear) else $error("enable kept");
   property p_direct;
      mvp && !(sfr_rdata[FEPW_BIT_DEFER] && ce_enable)
         && !sfr_rdata[FEPW_BIT_WAIT] && ok |=> flash_wr;
   endproperty
   a_direct: assert property (p_direct) else $error("no write");
   property p_post;
      mvp && sfr_rdata[FEPW_BIT_DEFER] && !sfr_rdata[FEPW_BIT_WAIT] && ok
         && ce_enable && ce_busy |=> !flash_wr && (!ctl || sfr_rdata[3]);
   endproperty
   a_post: assert property (p_post) else $error("not queued");
   property p_pop;
      ctl && sfr_rdata[FEPW_BIT_WAIT] && $fell(ce_busy) |=> flash_wr;
   endproperty
   a_pop: assert property (p_pop) else $error("queue not run");
   property p_ignore;
      ctl && sfr_rdata[FEPW_BIT_WAIT] && movx_wr && ce_busy |=> !flash_wr;
   endproperty
   a_ignore: assert property (p_ignore) else $error("extra write");
   c_page: cover property (page_erase);
   c_mass: cover property (mass_erase);
   c_pop: cover property (ctl && sfr_rdata[FEPW_BIT_WAIT] && $fell(ce_busy));
endmodule
bind fepw_ctrl fepw_ctrl_chk u_chk (.*);
`default_nettype wire

//--- test/fepw_flash_model.sv
// Partner: behavioural program flash array answering each operation with done
`timescale 1ns/1ps
`default_nettype none
module fepw_flash_model (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic flash_wr,
   input wire logic page_erase,
   input wire logic mass_erase,
   input wire logic slow,
   output logic flash_done
);
   // ***********************************************
   // Operation timer
   // ***********************************************
   logic [3:0] cnt_q; // Cycles left in the running operation
   // Slow mode stretches the operation so the control must really wait
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_q <= 4'h0;
         flash_done <= 1'h0;
      end else begin
         flash_done <= (cnt_q == 4'h1);
         if (flash_wr | page_erase | mass_erase) begin
            cnt_q <= slow ? 4'h6 : 4'h1;
         end else if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
         end
      end
   end
endmodule
`default_nettype wire

//--- test/tb.sv
// Testbench: erase keys, page index, direct and deferred flash writes
`timescale 1ns/1ps
`default_nettype none
module tb;
   import fepw_pkg::*;
   logic clk = 1'h0, reset_n = 1'h0, sfr_wr = 1'h0, movx_wr = 1'h0;
   logic irq_global_en = 1'h0, debug_port_link = 1'h0, slow = 1'h0;
   logic ce_enable = 1'h0, ce_busy = 1'h0, flash_done;
   logic [7:0] sfr_addr = FEPW_ADDR_CTRL, sfr_wdata = 8'h00;
   logic [7:0] movx_data = 8'h00, sfr_rdata, flash_data, xram_data;
   logic [15:0] movx_addr = 16'h0000, flash_addr, xram_addr;
   logic [3:0] modify_unlock_key = 4'h2;
   logic flash_wr, page_erase, mass_erase, xram_wr;
   logic [5:0] erase_page;
   logic [1:0] program_bank_select;
   logic [31:0] q[$]; // Expected events, oldest first
   int n_mismatch = 0, check_count = 0;
   integer seed = 32'h2c5478e5;
   always #4 clk = ~clk;
   fepw_ctrl dut (.*);
   fepw_flash_model u_flash (.*);
   // ***********************************************
   // Compare, report and bus tasks
   // ***********************************************
   task automatic cmp(input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("BAD t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   task automatic chk(input logic [7:0] e, input logic [7:0] g);
      cmp({24'h0, e}, {24'h0, g});
   endtask
   task automatic results;
      $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Address parks on the control register so its bits stay visible
   task automatic sw(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      {sfr_addr, sfr_wdata, sfr_wr} = {a, d, 1'h1};
      @(negedge clk);
      {sfr_addr, sfr_wr} = {FEPW_ADDR_CTRL, 1'h0};
   endtask
   task automatic mv(input logic [15:0] a, input logic [7:0] d);
      @(negedge clk);
      {movx_addr, movx_data, movx_wr} = {a, d, 1'h1};
      @(negedge clk);
      movx_wr = 1'h0;
   endtask
   // Bounded wait for the array to finish
   task automatic wdone;
      int i;
      i = 0;
      while (flash_done !== 1'h1 && i < 20) begin
         @(negedge clk);
         i++;
      end
      if (i == 20) begin
         n_mismatch++;
         results();
      end
   endtask
   // ***********************************************
   // Monitor: each output event takes the oldest note
   // ***********************************************
   task automatic take(input logic [31:0] g);
      if (q.size() == 0) cmp(32'hffffffff, g);
      else cmp(q.pop_front(), g);
   endtask
   always @(negedge clk) begin
      if (reset_n) begin
         if (flash_wr === 1'h1) take({8'h01, flash_addr, flash_data});
         if (page_erase === 1'h1) take({8'h02, 18'h0, erase_page});
         if (mass_erase === 1'h1) take({8'h03, 24'h0});
         if (xram_wr === 1'h1) take({8'h04, xram_addr, xram_data});
      end
   end
   // ***********************************************
   // Main sequence
   // ***********************************************
   initial begin
      int i;
      logic [5:0] p;
      logic [15:0] a;
      logic [7:0] d;
      repeat (3) @(negedge clk);
      reset_n = 1'h1;
      chk(8'h00, sfr_rdata);
      // Bank select: reset value, then a random write read back
      chk(8'h01, {6'h00, program_bank_select});
      d = 8'($random(seed));
      sw(FEPW_ADDR_BANK, d);
      chk({6'h00, d[1:0]}, {6'h00, program_bank_select});
      sfr_addr = FEPW_ADDR_BANK;
      #1;
      chk({6'h00, d[1:0]}, sfr_rdata);
      sfr_addr = FEPW_ADDR_CTRL;
      // Page erase at both ends of the index and one random page
      for (i = 0; i < 3; i++) begin
         p = (i == 0) ? 6'h00 : (i == 1) ? 6'h3f : 6'($random(seed));
         slow = i[0];
         q.push_back({8'h02, 18'h0, p});
         sw(FEPW_ADDR_PAGE, {p, 2'h0});
         sw(FEPW_ADDR_ERASE, FEPW_KEY_PAGE);
         wdone();
      end
      // Refused: stale page, junk keys, unarmed, no debug, locked
      sw(FEPW_ADDR_ERASE, FEPW_KEY_PAGE);
      sw(FEPW_ADDR_ERASE, 8'h54);
      sw(FEPW_ADDR_ERASE, 8'hab);
      sw(FEPW_ADDR_ERASE, FEPW_KEY_MASS);
      sw(FEPW_ADDR_CTRL, 8'h02);
      sw(FEPW_ADDR_ERASE, FEPW_KEY_MASS);
      modify_unlock_key = 4'h3;
      sw(FEPW_ADDR_PAGE, 8'h04);
      sw(FEPW_ADDR_ERASE, FEPW_KEY_PAGE);
      modify_unlock_key = 4'h2;
      debug_port_link = 1'h1;
      q.push_back({8'h03, 24'h0});
      sw(FEPW_ADDR_CTRL, 8'h02);
      sw(FEPW_ADDR_ERASE, FEPW_KEY_MASS);
      wdone();
      // Arm was consumed: a second mass key must do nothing
      sw(FEPW_ADDR_ERASE, FEPW_KEY_MASS);
      // Direct write with the engine off, then enable must be gone
      a = 16'($random(seed));
      d = 8'($random(seed));
      // Deferred off, then deferred on with the engine off
      for (i = 0; i < 2; i++) begin
         q.push_back({8'h01, a, d});
         sw(FEPW_ADDR_CTRL, (i != 0) ? 8'h05 : 8'h01);
         mv(a, d);
         wdone();
      end
      q.push_back({8'h04, a, ~d});
      mv(a, ~d);
      irq_global_en = 1'h1;
      sw(FEPW_ADDR_CTRL, 8'h05);
      q.push_back({8'h04, a, d});
      mv(a, d);
      irq_global_en = 1'h0;
      // Deferred write held until busy falls; a second one is dropped
      {ce_enable, ce_busy} = 2'h3;
      q.push_back({8'h01, a, d});
      sw(FEPW_ADDR_CTRL, 8'h05);
      mv(a, d);
      chk(8'h0c, sfr_rdata);
      sw(FEPW_ADDR_CTRL, 8'h05);
      mv(~a, d);
      repeat (3) @(negedge clk);
      ce_busy = 1'h0;
      wdone();
      chk(8'h04, sfr_rdata);
      repeat (4) @(negedge clk);
      cmp(32'h0, q.size());
      results();
   end
endmodule
`default_nettype wire
